// ---- verilog/iad_cfg.svh ----
// Register offsets, field positions and reset values of the align and decode block.
`ifndef IAD_CFG_SVH
`define IAD_CFG_SVH
`define IAD_OFS_CTRL 4'h0
`define IAD_OFS_STATUS 4'h4
`define IAD_OFS_DECODE 4'h8
`define IAD_OFS_TADDR 4'hC
`define IAD_CTRL_DBL 0
`define IAD_CTRL_SHORT 1
`define IAD_CTRL_RST 2'h0
`define IAD_RESP_OK 2'h0
`define IAD_RESP_ERR 2'h2
`define IAD_LEN_BIT 5
`define IAD_WORD_W 16
`define IAD_TADDR_W 13
`define IAD_ENTRY_W 12
`define IAD_CTRLBITS_W 6
`define IAD_PAR_W 2
`define IAD_RF_W 4
`endif

// ---- verilog/iad_pkg.sv ----
// Types shared by the align and decode block.
`include "iad_cfg.svh"
package iad_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_S3 = 2'b01,
        ST_S4 = 2'b10,
        ST_S5 = 2'b11
    } iad_state_t;
    typedef enum logic [2:0] {
        CLS_GEN = 3'b000,
        CLS_SHIFT = 3'b001,
        CLS_SKIP = 3'b010,
        CLS_REG = 3'b011,
        CLS_MEM_A = 3'b100,
        CLS_MEM_V = 3'b101,
        CLS_MEM_C = 3'b110,
        CLS_MEM_D = 3'b111
    } iad_class_t;
    typedef struct packed {
        logic [`IAD_WORD_W-1:0] first;
        logic [`IAD_WORD_W-1:0] second;
    } iad_fetch_t;
    typedef struct packed {
        logic [`IAD_WORD_W-1:0] high;
        logic [`IAD_WORD_W-1:0] low;
    } iad_bus_t;
    typedef struct packed {
        logic [`IAD_PAR_W-1:0] parity;
        logic [`IAD_CTRLBITS_W-1:0] ctrl;
        logic [`IAD_ENTRY_W-1:0] entry;
    } iad_dec_t;
endpackage

// ---- verilog/iad_align.sv ----
// Word swap multiplexers that place opcode and displacement on the bus halves.
`timescale 1ns/1ps
`include "iad_cfg.svh"
module iad_align
    import iad_pkg::*;
(
    input wire iad_fetch_t fetchWords,
    input wire logic [`IAD_WORD_W-1:0] heldWord,
    input wire logic [`IAD_WORD_W-1:0] nextWord,
    input wire logic nextValid,
    input wire logic pcLsb,
    input wire logic isLong,
    input wire iad_bus_t curBus,
    output iad_bus_t busStage3,
    output iad_bus_t busStage5,
    output logic swapNeeded
);
    always_comb begin
        busStage3.high = pcLsb ? fetchWords.second : fetchWords.first; // RULE9
        busStage3.low = pcLsb ? fetchWords.first : fetchWords.second; // RULE4
        busStage5 = curBus;
        if (!pcLsb && !isLong) begin
            busStage5.high = heldWord; // RULE7
        end
        if (!pcLsb && isLong) begin
            busStage5.low = heldWord; // RULE8
        end
        if (pcLsb && isLong && nextValid) begin
            busStage5.low = nextWord; // RULE10
        end
        swapNeeded = (!pcLsb && !isLong) || (pcLsb && isLong); // RULE5
    end
endmodule

// ---- verilog/iad_addr_gen.sv ----
// Decode table address former, one bit pattern per instruction class.
`timescale 1ns/1ps
`include "iad_cfg.svh"
module iad_addr_gen
    import iad_pkg::*;
(
    input wire logic [`IAD_WORD_W-1:0] opcode,
    input wire iad_class_t instrClass,
    input wire logic doubleKeyN,
    input wire logic shortFormat,
    output logic [`IAD_TADDR_W-1:0] tableAddr,
    output logic tagNonzeroFlag
);
    // Opcode bits are numbered 1 to 16 from the most significant end.
    function automatic logic op(input logic [15:0] w, input int n);
        op = w[16-n];
    endfunction

    logic g13;
    logic g14;
    logic [12:1] lookupAddressBits;
    always_comb begin
        // Displacement bits of a short memory format must not steer decode.
        g13 = shortFormat ? 1'b0 : op(opcode, 13); // RULE18
        g14 = shortFormat ? 1'b0 : op(opcode, 14); // RULE18
        tagNonzeroFlag = op(opcode, 10) | op(opcode, 11); // RULE19
        // The leading constant bits split the table into class ranges.
        unique case (instrClass) // RULE16 RULE22
            CLS_GEN: lookupAddressBits = {1'b0, op(opcode, 2),
                op(opcode, 7), op(opcode, 8), opcode[7:0]};
            CLS_SHIFT: lookupAddressBits = {3'h7, 1'b0, opcode[7:4],
                op(opcode, 7), op(opcode, 8), opcode[1:0]};
            CLS_SKIP: lookupAddressBits = {4'hA, opcode[7:0]};
            CLS_REG: lookupAddressBits = {1'b1, op(opcode, 2), 2'h3,
                opcode[7:0]};
            CLS_MEM_A: lookupAddressBits = {1'b1, op(opcode, 2), 1'b0,
                g13, g14, doubleKeyN, 2'h2, op(opcode, 6), op(opcode, 5),
                ~op(opcode, 4), ~op(opcode, 3)};
            CLS_MEM_V: lookupAddressBits = {1'b1, op(opcode, 2), 1'b0,
                g13, g14, 3'h4, op(opcode, 6), op(opcode, 5),
                ~op(opcode, 4), ~op(opcode, 3)};
            CLS_MEM_C: lookupAddressBits = {1'b1, op(opcode, 2), 1'b0,
                tagNonzeroFlag, ~op(opcode, 4), 3'h0, op(opcode, 6),
                op(opcode, 5), ~op(opcode, 1), ~op(opcode, 3)};
            CLS_MEM_D: lookupAddressBits = {1'b1, op(opcode, 2), 1'b0,
                tagNonzeroFlag, op(opcode, 9), 3'h1, op(opcode, 7),
                op(opcode, 8), ~op(opcode, 1), ~op(opcode, 3)};
        endcase
        tableAddr = {doubleKeyN, lookupAddressBits}; // RULE17
    end
endmodule

// ---- verilog/iad_top.sv ----
// Instruction align and decode front end with its AXI4-Lite register slave.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "iad_cfg.svh"
// Operation
// (RULE1) Take two fetched 16-bit words in stage 2, clock them in at its end.
// (RULE2) Program counter low bit zero means aligned, one means unaligned.
// (RULE3) Present the freshly fetched words on the bus during stage 3.
// (RULE4) Opcode always on bus high half, displacement always on low half.
// (RULE5) Swap when previous instruction was aligned short or unaligned long.
// (RULE6) Length from first control bit for generics, else from address unit; the code reads the control bit for the register class too.
// (RULE7) Aligned fetch holds second word to stage 5; short puts it high.
// (RULE8) Aligned long drives the held word on the low half as displacement.
// (RULE9) Unaligned fetch puts the second word, the opcode, on the high half.
// (RULE10) Unaligned long takes displacement from next fetch onto low half.
// (RULE11) Latch the bus opcode at end of stage 3, register decode at stage 4.
// (RULE12) Entry point addresses control store in stage 5 unless help needed.
// (RULE13) Base and index file addresses clocked at end of stage 4.
// (RULE14) Map opcode in stage 3, read table in stage 4, register entry.
// (RULE15) Table word: 12 entry bits, 6 control bits, 2 parity bits.
// (RULE16) Table addresses are partitioned into ranges by instruction class.
// (RULE17) Table address is 13 bits: twelve class bits plus precision bit.
// (RULE18) Gated opcode bits 13, 14 forced to zero for short displacement.
// (RULE19) Tag flag is zero only when both tag modifier bits are zero.
// (RULE20) Active-low precision key reads zero when precision bit is set.
// (RULE21) First control bit is one for two-word, zero for one-word generic.
// (RULE22) Each class drives every address bit from a constant or a source.
module iad_top
    import iad_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fetchValid,
    input wire iad_fetch_t fetchWords,
    input wire logic pcLsb,
    input wire iad_class_t instrClass,
    input wire logic eafLong,
    input wire logic multiStep,
    input wire logic eafHelp,
    input wire iad_dec_t tableData,
    output iad_bus_t busB,
    output logic [`IAD_TADDR_W-1:0] tableAddr,
    output logic [`IAD_ENTRY_W-1:0] csAddr,
    output logic csValid,
    output logic [`IAD_CTRLBITS_W-1:0] ctrlBits,
    output logic [`IAD_RF_W-1:0] baseRf,
    output logic [`IAD_RF_W-1:0] indexRf,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    iad_state_t stateQ;
    iad_fetch_t fetchQ;
    logic pcLsbQ;
    iad_class_t classQ;
    logic [`IAD_WORD_W-1:0] heldQ;
    logic [`IAD_WORD_W-1:0] opcodeQ;
    iad_dec_t decQ;
    logic swapQ;
    logic longQ;
    logic [1:0] ctrlRegQ;
    iad_bus_t busStage3;
    iad_bus_t busStage5;
    logic swapNeeded;
    logic isLong;
    logic tagNonzeroFlag;
    logic [`IAD_TADDR_W-1:0] addrNext;
    logic doubleKeyN;

    // The double-precision key pin is active low.
    assign doubleKeyN = ~ctrlRegQ[`IAD_CTRL_DBL]; // RULE20
    // Generic and register classes carry their length in the table; others ask the address unit.
    assign isLong = (classQ == CLS_GEN || classQ == CLS_REG) ?
        tableData.ctrl[`IAD_LEN_BIT] : eafLong; // RULE6 RULE21

    iad_align u_align (
        .fetchWords(fetchQ),
        .heldWord(heldQ),
        .nextWord(fetchWords.first),
        .nextValid(fetchValid),
        .pcLsb(pcLsbQ),
        .isLong(isLong),
        .curBus(busB),
        .busStage3(busStage3),
        .busStage5(busStage5),
        .swapNeeded(swapNeeded)
    );

    iad_addr_gen u_addr_gen (
        .opcode(busB.high),
        .instrClass(classQ),
        .doubleKeyN(doubleKeyN),
        .shortFormat(ctrlRegQ[`IAD_CTRL_SHORT]),
        .tableAddr(addrNext),
        .tagNonzeroFlag(tagNonzeroFlag)
    );

    // One beat per stage; a new fetch is taken only from idle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ <= ST_IDLE;
        end else begin
            unique case (stateQ)
                ST_IDLE: stateQ <= fetchValid ? ST_S3 : ST_IDLE;
                ST_S3: stateQ <= ST_S4;
                ST_S4: stateQ <= ST_S5;
                ST_S5: stateQ <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetchQ <= '0;
            pcLsbQ <= 1'b0;
            classQ <= CLS_GEN;
            heldQ <= '0;
        end else if (stateQ == ST_IDLE && fetchValid) begin
            fetchQ <= fetchWords; // RULE1
            pcLsbQ <= pcLsb; // RULE2
            classQ <= instrClass;
            if (!pcLsb) begin
                heldQ <= fetchWords.second; // RULE7
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busB <= '0;
        end else if (stateQ == ST_IDLE && fetchValid) begin
            busB.high <= pcLsb ? fetchWords.second : fetchWords.first; // RULE3
            busB.low <= pcLsb ? fetchWords.first : fetchWords.second; // RULE4
        end else if (stateQ == ST_S4) begin
            busB <= busStage5; // RULE7 RULE8 RULE10
        end
    end

    // Stage 3 maps the latched opcode; stage 4 reads the table.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opcodeQ <= '0;
            tableAddr <= '0;
        end else if (stateQ == ST_S3) begin
            opcodeQ <= busB.high; // RULE11
            tableAddr <= addrNext; // RULE14
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            decQ <= '0;
            ctrlBits <= '0;
            baseRf <= '0;
            indexRf <= '0;
            swapQ <= 1'b0;
            longQ <= 1'b0;
        end else if (stateQ == ST_S4) begin
            decQ <= tableData; // RULE11 RULE14 RULE15
            ctrlBits <= tableData.ctrl; // RULE15
            // Register-to-register forms name the file slot in the low bits.
            baseRf <= tagNonzeroFlag ? {2'h3, opcodeQ[11:10]} :
                opcodeQ[3:0]; // RULE13
            indexRf <= {2'h0, opcodeQ[15:14]}; // RULE13
            swapQ <= swapNeeded; // RULE5
            longQ <= isLong; // RULE6
        end
    end

    // Stepping microcode or helped address formation keeps control store.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csAddr <= '0;
            csValid <= 1'b0;
        end else if (stateQ == ST_S4) begin
            csAddr <= tableData.entry;
            csValid <= !multiStep && !eafHelp; // RULE12
        end else if (stateQ == ST_S5) begin
            csValid <= 1'b0;
        end
    end

    logic awFullQ;
    logic wFullQ;
    logic [ADDR_W-1:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic doWrite;
    logic awFullD;
    logic wFullD;

    assign doWrite = awFullQ && wFullQ && !bvalid;

    always_comb begin
        awFullD = awFullQ;
        wFullD = wFullQ;
        if (awvalid && awready) begin
            awFullD = 1'b1;
        end
        if (wvalid && wready) begin
            wFullD = 1'b1;
        end
        if (doWrite) begin
            awFullD = 1'b0;
            wFullD = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awFullQ <= 1'b0;
            wFullQ <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= 4'h0;
        end else begin
            awFullQ <= awFullD;
            wFullQ <= wFullD;
            awready <= !awFullD;
            wready <= !wFullD;
            if (awvalid && awready) begin
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlRegQ <= `IAD_CTRL_RST;
            bvalid <= 1'b0;
            bresp <= `IAD_RESP_OK;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            if (awAddrQ == `IAD_OFS_CTRL) begin
                bresp <= `IAD_RESP_OK;
                if (wStrbQ[0]) begin
                    ctrlRegQ <= wDataQ[1:0];
                end
            end else begin
                bresp <= `IAD_RESP_ERR;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Reads of unmapped words answer an error and zero data.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `IAD_RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `IAD_RESP_OK;
            unique case (araddr)
                `IAD_OFS_CTRL: rdata <= {30'h0, ctrlRegQ};
                `IAD_OFS_STATUS: rdata <= {24'h0, 2'h0, stateQ, swapQ,
                    longQ, csValid, pcLsbQ};
                `IAD_OFS_DECODE: rdata <= {12'h000, decQ};
                `IAD_OFS_TADDR: rdata <= {19'h0, tableAddr};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `IAD_RESP_ERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end
    property p_fetch_take;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_IDLE && fetchValid) |=>
            (stateQ == ST_S3 && fetchQ == $past(fetchWords));
    endproperty
    a_fetch_take: assert property (p_fetch_take) // RULE1
        else $error("Fetch pair not taken at end of stage 2.");
    property p_opcode_high;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S3) |-> (busB == busStage3);
    endproperty
    a_opcode_high: assert property (p_opcode_high) // RULE9
        else $error("Opcode word not on bus high half in stage 3.");
    property p_walk;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S3) |=> (stateQ == ST_S4) ##1 (stateQ == ST_S5)
            ##1 (stateQ == ST_IDLE);
    endproperty
    a_walk: assert property (p_walk) // RULE11
        else $error("Stage sequence broken after stage 3.");
    property p_map_addr;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S3) |=>
            (tableAddr == $past(addrNext) && opcodeQ == $past(busB.high));
    endproperty
    a_map_addr: assert property (p_map_addr) // RULE14
        else $error("Table address not registered at end of stage 3.");
    property p_decode_reg;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S4) |=> (decQ == $past(tableData) &&
            ctrlBits == $past(tableData.ctrl));
    endproperty
    a_decode_reg: assert property (p_decode_reg) // RULE15
        else $error("Table word not registered at end of stage 4.");
    property p_cs_issue;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S4 && !multiStep && !eafHelp) |=>
            (csValid && csAddr == $past(tableData.entry)) ##1 !csValid;
    endproperty
    a_cs_issue: assert property (p_cs_issue) // RULE12
        else $error("Entry point not issued for exactly stage 5.");
    property p_aligned_long;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S4 && !pcLsbQ && isLong) |=>
            (busB.low == $past(heldQ) && swapQ == 1'b0);
    endproperty
    a_aligned_long: assert property (p_aligned_long) // RULE8
        else $error("Held displacement missing on bus low half.");
    property p_aligned_short;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S4 && !pcLsbQ && !isLong) |=>
            (busB.high == $past(heldQ) && swapQ);
    endproperty
    a_aligned_short: assert property (p_aligned_short) // RULE7
        else $error("Held opcode not swapped onto bus high half.");
    property p_unaligned_long;
        @(posedge clk) disable iff (sys_rst)
        (stateQ == ST_S4 && pcLsbQ && isLong && fetchValid) |=>
            (busB.low == $past(fetchWords.first) && swapQ);
    endproperty
    a_unaligned_long: assert property (p_unaligned_long) // RULE10
        else $error("Next fetch displacement not on bus low half.");

    c_aligned_short: cover property (@(posedge clk) disable iff (sys_rst)
        stateQ == ST_S4 && !pcLsbQ && !isLong);
    c_unaligned_long: cover property (@(posedge clk) disable iff (sys_rst)
        stateQ == ST_S4 && pcLsbQ && isLong && fetchValid);
    c_cs_issue: cover property (@(posedge clk) disable iff (sys_rst)
        stateQ == ST_S5 && csValid);
endmodule

// ---- verification/iad_far_model.sv ----
// Decode table stand-in that answers the block's lookup address.
`timescale 1ns/1ps
module iad_far_model
    import iad_pkg::*;
(
    input wire logic [12:0] tableAddr,
    input wire logic longSel,
    output iad_dec_t tableData
);
    // The content is a fixed scramble of the address, so that a wrong
    // address shows as a wrong entry; only the length bit is steered.
    always_comb begin
        tableData.entry = tableAddr[11:0] ^ 12'hC3C;
        tableData.ctrl = {longSel, tableAddr[12:8]};
        tableData.parity = {^tableData.ctrl, ^tableData.entry};
    end
endmodule

// ---- verification/iad_top_tb.sv ----
// Self-checking bench for the instruction align and decode block.
`timescale 1ns/1ps
`include "iad_cfg.svh"
module iad_top_tb
    import iad_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic fetchValid = 1'b0;
    logic pcLsb = 1'b0;
    logic eafLong = 1'b0;
    logic multiStep = 1'b0;
    logic eafHelp = 1'b0;
    logic longSel = 1'b0;
    iad_fetch_t fetchWords = '0;
    iad_class_t instrClass = CLS_GEN;
    iad_dec_t tableData;
    iad_bus_t busB;
    logic [12:0] tableAddr;
    logic [11:0] csAddr;
    logic csValid;
    logic [5:0] ctrlBits;
    logic [3:0] baseRf;
    logic [3:0] indexRf;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, r, lastWord;
    logic [12:0] lastAddr;
    logic dbl = 1'b0;
    logic shortF = 1'b0;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    iad_top #(.ADDR_W(4)) uut (.clk, .sys_rst, .fetchValid, .fetchWords,
        .pcLsb, .instrClass, .eafLong, .multiStep, .eafHelp, .tableData,
        .busB, .tableAddr, .csAddr, .csValid, .ctrlBits, .baseRf, .indexRf,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready);

    iad_far_model far (.tableAddr, .longSel, .tableData);

    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h want %h", $time, s, got, exp);
        end
    endtask

    task print_verdict;
        $display("Counts: %0d compared, %0d failed", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            print_verdict();
        end
    end

    task axi_wr(input logic [3:0] a, input logic [31:0] d,
                input logic [3:0] s, output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task axi_rd(input logic [3:0] a, output logic [31:0] d,
                output logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task set_ctrl(input logic [1:0] v);
        axi_wr(`IAD_OFS_CTRL, 32'(v), 4'hF, rs);
        chk(32'(rs), 32'(`IAD_RESP_OK), "ctrl write");
        dbl = v[`IAD_CTRL_DBL];
        shortF = v[`IAD_CTRL_SHORT];
    endtask

    // Opcode bit n sits at word bit 16-n, so an ascending vector lines up.
    function automatic logic [12:0] exp_addr(input logic [1:16] o,
                                             input iad_class_t c);
        logic g13, g14, t;
        g13 = o[13] & ~shortF;
        g14 = o[14] & ~shortF;
        t = o[10] | o[11];
        case (c)
            CLS_GEN: return {~dbl, 1'b0, o[2], o[7:16]};
            CLS_SHIFT: return {~dbl, 4'b1110, o[9:12], o[7:8], o[15:16]};
            CLS_SKIP: return {~dbl, 4'b1010, o[9:16]};
            CLS_REG: return {~dbl, 1'b1, o[2], 2'b11, o[9:16]};
            CLS_MEM_A: return {~dbl, 2'b10 | o[2], 1'b0, g13, g14, ~dbl,
                               2'b10, o[6], o[5], ~o[4], ~o[3]};
            CLS_MEM_V: return {~dbl, 2'b10 | o[2], 1'b0, g13, g14, 3'b100,
                               o[6], o[5], ~o[4], ~o[3]};
            CLS_MEM_C: return {~dbl, 2'b10 | o[2], 1'b0, t, ~o[4], 3'b000,
                               o[6], o[5], ~o[1], ~o[3]};
            default: return {~dbl, 2'b10 | o[2], 1'b0, t, o[9], 3'b001,
                             o[7], o[8], ~o[1], ~o[3]};
        endcase
    endfunction

    task run(input logic [1:16] op, input iad_class_t c, input logic pc,
             input logic lng, input logic ms, input logic hlp);
        logic gen, t;
        logic [12:0] ea;
        logic [15:0] w2;
        logic [5:0] cb;
        logic [3:0] rb;
        gen = (c == CLS_GEN) || (c == CLS_REG);
        t = op[10] | op[11];
        w2 = ~op;
        ea = exp_addr(op, c);
        cb = {gen ? lng : ~lng, ea[12:8]};
        rb = t ? {2'b11, op[5:6]} : op[13:16];
        @(posedge clk);
        fetchValid <= 1'b1;
        fetchWords <= pc ? {w2, op} : {op, w2};
        pcLsb <= pc;
        instrClass <= c;
        multiStep <= ms;
        eafHelp <= hlp;
        eafLong <= gen ? ~lng : lng;
        longSel <= gen ? lng : ~lng;
        @(posedge clk);
        fetchValid <= 1'b0;
        #1;
        chk(busB, {op, w2}, "stage 3 bus");
        // The displacement fetch must stand while the design is in stage 4.
        @(posedge clk);
        if (pc && lng) begin
            fetchValid <= 1'b1;
            fetchWords <= {16'h3C5A, 16'h0F0F};
        end
        #1;
        chk(32'(tableAddr), 32'(ea), "table addr");
        @(posedge clk);
        fetchValid <= 1'b0;
        #1;
        if (!pc && !lng)
            chk(32'(busB.high), 32'(w2), "next opcode");
        else
            chk(busB, {op, pc && lng ? 16'h3C5A : w2}, "bus");
        chk(32'(csAddr), 32'(ea[11:0] ^ 12'hC3C), "entry");
        chk(32'(csValid), 32'(!ms && !hlp), "entry valid");
        chk(32'(ctrlBits), 32'(cb), "control bits");
        chk(32'(baseRf), 32'(rb), "base");
        chk(32'(indexRf), 32'({2'b00, op[1:2]}), "index");
        @(posedge clk);
        #1;
        chk(32'(csValid), 32'h0, "entry valid drop");
        lastAddr = ea;
        lastWord = 32'({^cb, ^(ea[11:0] ^ 12'hC3C), cb, ea[11:0] ^ 12'hC3C});
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(`IAD_OFS_CTRL, r, rs);
        chk(r, 32'h0, "ctrl reset");
        axi_rd(`IAD_OFS_STATUS, r, rs);
        chk(r, 32'h0, "status reset");
        axi_rd(4'h2, r, rs);
        chk(32'(rs), 32'(`IAD_RESP_ERR), "unmapped read");
        axi_wr(`IAD_OFS_STATUS, 32'hF, 4'hF, rs);
        chk(32'(rs), 32'(`IAD_RESP_ERR), "read-only write");
        axi_wr(`IAD_OFS_CTRL, 32'h3, 4'h0, rs);
        axi_rd(`IAD_OFS_CTRL, r, rs);
        chk(r, 32'h0, "strobe gating");
        // Each pass runs every class once, cycling through the four fetch shapes.
        for (int p = 0; p < 2; p++) begin
            set_ctrl(p[0] ? 2'h3 : 2'h0);
            for (int i = 0; i < 8; i++)
                run(p[0] ? 16'h5A1C : 16'hA5CF, iad_class_t'(3'(i)), i[0],
                    i[1], i == 5, i == 6);
        end
        axi_rd(`IAD_OFS_TADDR, r, rs);
        chk(r, 32'(lastAddr), "last address");
        axi_rd(`IAD_OFS_DECODE, r, rs);
        chk(r, lastWord, "last table word");
        print_verdict();
    end
endmodule
